// ---- design/slic_fifo.sv ----
// Sample FIFO with registered read port
`timescale 1ns/100ps
module slic_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             nrst,
	// Fill side
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output wire logic             inReady,
	// Drain side
	output wire logic             outValid,
	output wire logic [WIDTH-1:0] outData,
	input  wire logic             outReady
);

	// Pointers wrap naturally, so DEPTH must be a power of two
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_q;
	logic [AW-1:0]    rdPtr_q;
	logic [AW:0]      count_q;
	logic             outValid_q;
	logic [WIDTH-1:0] outData_q;

	wire push = inValid & inReady;
	wire load = (count_q != '0) & (~outValid_q | outReady);

	assign inReady  = count_q != (AW+1)'(DEPTH);
	assign outValid = outValid_q;
	assign outData  = outData_q;

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wrPtr_q] <= inData;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wrPtr_q    <= '0;
			rdPtr_q    <= '0;
			count_q    <= '0;
			outValid_q <= 1'b0;
			outData_q  <= '0;
		end else begin
			wrPtr_q    <= push ? wrPtr_q + 1'b1 : wrPtr_q;
			rdPtr_q    <= load ? rdPtr_q + 1'b1 : rdPtr_q;
			count_q    <= count_q + (AW+1)'(push) - (AW+1)'(load);
			outValid_q <= load | (outValid_q & ~outReady);
			outData_q  <= load ? mem[rdPtr_q] : outData_q;
		end
	end

endmodule

// ---- design/slic_link_init.sv ----
// Link bring-up controller: frame clocks, sync handling, lane alignment and data
`timescale 1ns/100ps
module slic_link_init
	import slic_pkg::*;
#(
	parameter int PLL_CAL_CYCLES = PLL_CAL_SAMPLE_CYCLES,
	parameter int ADC_CAL_CYCLES = ADC_CAL_CYCLES_DFLT
) (
	// Device clock and reset
	input  wire logic                    mclk,
	input  wire logic                    nrst,
	// Configuration and power mode
	input  wire slic_cfg_t               cfg,
	input  wire logic [1:0]              powerMode,
	// Link control pins
	input  wire logic                    linkSyncRequestN,
	input  wire logic                    systemReferencePulse,
	// Sample stream in
	input  wire logic [SAMPLE_W-1:0]     sampleData,
	input  wire logic                    sampleValid,
	output wire logic                    sampleReady,
	// Serial lanes out
	output wire slic_lane_t [LANES-1:0]  laneOut,
	// Status
	output wire slic_status_t            linkStatusRegister
);

	localparam logic [CAL_W-1:0] PLL_LAST = CAL_W'(PLL_CAL_CYCLES - 1);
	localparam logic [CAL_W-1:0] ADC_LAST = CAL_W'(ADC_CAL_CYCLES - 1);

	slic_state_t              state_q;
	slic_state_t              state_d;
	logic [CAL_W-1:0]         calCnt_q;
	logic [CAL_W-1:0]         calCnt_d;
	logic                     frameCnt_q;
	logic                     frameCnt_d;
	logic [4:0]               mfCnt_q;
	logic [4:0]               mfCnt_d;
	logic [1:0]               ilaCnt_q;
	logic [1:0]               ilaCnt_d;
	logic [2:0]               syncLow_q;
	logic [2:0]               syncLow_d;
	logic                     syncS_q;
	logic                     sysrefS_q;
	logic                     sysrefP_q;
	logic [SYSTEM_REFERENCE_PULSE_DELAY-1:0]  sysrefDly_q;
	logic                     calDone_q;
	logic                     realign_q;
	logic                     align_q;
	slic_status_t             status_q;
	slic_lane_t [LANES-1:0]   lane_q;
	wire slic_lane_t [LANES-1:0] lane_d;

	wire [SAMPLE_W-1:0] fifoData;
	wire                fifoValid;

	// Multiframe length, clamped to the legal range of the lane mode
	wire [4:0] kMin  = cfg.dualLane ? KM1_MIN_DUAL : KM1_MIN_SINGLE;
	wire [4:0] kLast = (cfg.kMinus1 < kMin) ? kMin : cfg.kMinus1;

	// Two octets per frame on one lane, one octet per frame on two
	wire frameLast = cfg.dualLane | frameCnt_q;
	wire lmfcEnd   = frameLast & (mfCnt_q == kLast);

	wire inCal     = (state_q == ST_ADCCAL) | (state_q == ST_PLLCAL);
	wire linkUp    = (state_q == ST_CGS) | (state_q == ST_ILA) | (state_q == ST_DATA);
	wire clocksRun = (state_q != ST_SLEEP) & (state_q != ST_PDOWN);
	wire linkTx    = linkUp | (state_q == ST_PLLCAL);

	// Reference pulse handling
	wire sysrefEdge  = sysrefS_q & ~sysrefP_q;
	wire sysrefEvent = sysrefDly_q[SYSTEM_REFERENCE_PULSE_DELAY-1];
	// Edges during calibration or low power are dropped, not trusted
	// Same states as linkUp, spelled out so sleep and power-down stay excluded
	wire sysrefCheck = sysrefEvent & clocksRun & ~inCal;
	wire lmfcMis     = sysrefCheck & ~lmfcEnd;
	wire frameMis    = lmfcMis & ~frameLast;

	// Sync request qualification
	wire syncValid = (syncLow_q == SYNC_MIN_FRAMES);
	wire syncIdle  = syncS_q;

	// Power mode decode
	wire pdReq    = powerMode[0];
	wire sleepReq = (powerMode == PM_SLEEP);

	wire calLast = (state_q == ST_ADCCAL) ? (calCnt_q == ADC_LAST) : (calCnt_q == PLL_LAST);

	// Octet position within the multiframe
	wire [5:0] octPos     = cfg.dualLane ? {1'b0, mfCnt_q} : {mfCnt_q, frameCnt_q};
	wire [3:0] cfgIdx     = 4'(octPos - ILA_CFG_FIRST);
	wire       ilaCfgMf   = (ilaCnt_q == ILA_CFG_MF);
	wire       ilaCfgSlot = ilaCfgMf & (octPos >= ILA_CFG_FIRST) & (octPos <= ILA_CFG_LAST);
	wire       ilaQSlot   = ilaCfgMf & (octPos == ILA_Q_POS);

	// One sample per frame leaves the FIFO while data flows
	wire fifoReady = (state_q == ST_DATA) & frameLast;

	function automatic logic [7:0] cfgOctet(
		input logic [3:0] idx,
		input logic       laneId,
		input slic_cfg_t  c,
		input logic [4:0] kl
	);
		logic [7:0] chk;
		logic [7:0] res;
		chk = 8'(laneId) + 8'(c.scrambleEn) + 8'(c.dualLane) + 8'(~c.dualLane) + 8'(kl)
			+ ILA_M1 + 8'(ILA_N1) + 8'(ILA_SUBCLASS) + 8'(ILA_NP1) + 8'(ILA_JESDV)
			+ 8'(ILA_S1) + 8'(c.dualLane);
		case (idx)
			4'h0: res = ILA_DID;
			4'h1: res = {4'h0, ILA_BID};
			4'h2: res = {7'h00, laneId};
			4'h3: res = {c.scrambleEn, 6'h00, c.dualLane};
			4'h4: res = {7'h00, ~c.dualLane};
			4'h5: res = {3'h0, kl};
			4'h6: res = ILA_M1;
			4'h7: res = {ILA_CS, 1'b0, ILA_N1};
			4'h8: res = {ILA_SUBCLASS, ILA_NP1};
			4'h9: res = {ILA_JESDV, ILA_S1};
			4'hA: res = {c.dualLane, 2'b00, ILA_CF};
			4'hD: res = chk;
			default: res = OCTET_NUL;
		endcase
		return res;
	endfunction

	// Link sequencer
	always_comb begin
		state_d = state_q;
		// Mode changes only move the sequencer; cfg is never touched here
		if (pdReq && state_q != ST_PDOWN) begin
			state_d = ST_PDOWN;
		end else if (sleepReq && state_q != ST_SLEEP && state_q != ST_PDOWN) begin
			state_d = ST_SLEEP;
		end else begin
			unique case (state_q)
				ST_ADCCAL: begin
					if (calLast) begin
						state_d = ST_PLLCAL;
					end
				end
				ST_PLLCAL: begin
					if (calLast) begin
						state_d = ST_CGS;
					end
				end
				ST_CGS: begin
					if (lmfcMis) begin
						state_d = ST_PLLCAL;
					end else if (lmfcEnd && syncIdle) begin
						state_d = ST_ILA;
					end
				end
				ST_ILA: begin
					if (lmfcMis) begin
						state_d = ST_PLLCAL;
					end else if (syncValid) begin
						state_d = ST_CGS;
					end else if (lmfcEnd && ilaCnt_q == ILA_LAST_MF) begin
						state_d = ST_DATA;
					end
				end
				ST_DATA: begin
					if (lmfcMis) begin
						state_d = ST_PLLCAL;
					end else if (syncValid) begin
						state_d = ST_CGS;
					end
				end
				ST_SLEEP: begin
					if (!sleepReq) begin
						state_d = ST_PLLCAL;
					end
				end
				ST_PDOWN: begin
					if (!pdReq) begin
						state_d = sleepReq ? ST_SLEEP : ST_ADCCAL;
					end
				end
				default: begin
					state_d = ST_ADCCAL;
				end
			endcase
		end
	end

	// Calibration timer restarts on every state change
	assign calCnt_d = (state_d != state_q) ? '0 : (calLast ? calCnt_q : calCnt_q + 1'b1);

	// Frame and multiframe counters
	always_comb begin
		frameCnt_d = ~frameLast;
		mfCnt_d    = frameLast ? (lmfcEnd ? 5'h00 : mfCnt_q + 5'h01) : mfCnt_q;
		if (!clocksRun) begin
			// Held at default phase so wake-up starts from a known point
			frameCnt_d = 1'b0;
			mfCnt_d    = 5'h00;
		end else if (frameMis) begin
			frameCnt_d = 1'b0;
			mfCnt_d    = 5'h00;
		end else if (lmfcMis) begin
			mfCnt_d = 5'h00;
		end
	end

	assign ilaCnt_d = (state_q != ST_ILA) ? 2'h0 : (lmfcEnd ? ilaCnt_q + 2'h1 : ilaCnt_q);

	// Count whole frames of low request; saturates at the qualifying length
	assign syncLow_d = syncS_q ? 3'h0 : ((frameLast && !syncValid) ? syncLow_q + 3'h1 : syncLow_q);

	// Lane octet generation
	for (genvar i = 0; i < LANES; i++) begin : gLane
		wire       laneOn  = linkTx & ((i == 0) | cfg.dualLane);
		wire [7:0] smpOct  = ((i == 0) & ~(cfg.dualLane | frameCnt_q)) | ((i == 0) & cfg.dualLane)
			? fifoData[15:8] : fifoData[7:0];
		wire [7:0] dataOct = fifoValid ? smpOct : OCTET_NUL;
		wire       ilaK    = lmfcEnd | (octPos == 6'h00) | ilaQSlot;
		wire [7:0] ilaOct  = lmfcEnd ? K28_3
			: (octPos == 6'h00) ? K28_0
			: ilaQSlot ? K28_4
			: ilaCfgSlot ? cfgOctet(cfgIdx, 1'(i), cfg, kLast)
			: {2'b00, octPos};
		wire       inIla   = (state_q == ST_ILA);
		wire       inData  = (state_q == ST_DATA);
		wire       isK     = inIla ? ilaK : ~inData;
		wire [7:0] octet   = ~laneOn ? OCTET_NUL : inIla ? ilaOct : inData ? dataOct : K28_5;
		wire       scr     = laneOn & inData & cfg.scrambleEn;
		assign lane_d[i] = {laneOn, laneOn & isK, scr, octet};
	end

	// Status word
	wire slic_status_t status_d = '{
		rsvd:    1'b0,
		link:    (state_q == ST_DATA),
		sync:    syncS_q,
		realign: realign_q,
		align:   align_q,
		pllLock: linkUp,
		calDone: calDone_q,
		clkRdy:  clocksRun
	};

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_q  <= ST_ADCCAL;
			calCnt_q <= '0;
		end else begin
			state_q  <= state_d;
			calCnt_q <= calCnt_d;
		end
	end

	// Free running from reset, starting from frame and multiframe zero
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			frameCnt_q <= 1'b0;
			mfCnt_q    <= 5'h00;
			ilaCnt_q   <= 2'h0;
		end else begin
			frameCnt_q <= frameCnt_d;
			mfCnt_q    <= mfCnt_d;
			ilaCnt_q   <= ilaCnt_d;
		end
	end

	// Pin samples; reset value is the idle level of each pin
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			syncS_q     <= 1'b1;
			syncLow_q   <= 3'h0;
			sysrefS_q   <= 1'b0;
			sysrefP_q   <= 1'b0;
			sysrefDly_q <= '0;
		end else begin
			syncS_q     <= linkSyncRequestN;
			syncLow_q   <= syncLow_d;
			sysrefS_q   <= systemReferencePulse;
			sysrefP_q   <= sysrefS_q;
			sysrefDly_q <= {sysrefDly_q[SYSTEM_REFERENCE_PULSE_DELAY-2:0], sysrefEdge};
		end
	end

	// Sticky status flags; calDone also clears in power-down
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			calDone_q <= 1'b0;
			realign_q <= 1'b0;
			align_q   <= 1'b0;
		end else begin
			calDone_q <= (state_q == ST_PDOWN) ? 1'b0 : (calDone_q | (state_q == ST_ADCCAL & calLast));
			realign_q <= realign_q | lmfcMis;
			align_q   <= align_q | sysrefCheck;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			status_q <= '0;
			lane_q   <= '0;
		end else begin
			status_q <= status_d;
			lane_q   <= lane_d;
		end
	end

	assign laneOut            = lane_q;
	assign linkStatusRegister = status_q;

	// Sample FIFO decouples the converter from frame pacing
	slic_fifo #(
		.WIDTH (SAMPLE_W),
		.DEPTH (FIFO_DEPTH)
	) uFifo (
		.mclk     (mclk),
		.nrst     (nrst),
		.inValid  (sampleValid),
		.inData   (sampleData),
		.inReady  (sampleReady),
		.outValid (fifoValid),
		.outData  (fifoData),
		.outReady (fifoReady)
	);

endmodule

// ---- design/slic_pkg.sv ----
// Shared constants and types of the serial link bring-up controller
package slic_pkg;

	// Datapath shape
	localparam int SAMPLE_W   = 16;
	localparam int FIFO_DEPTH = 16;
	localparam int LANES      = 2;

	// Control characters
	localparam logic [7:0] K28_5     = 8'hBC;
	localparam logic [7:0] K28_0     = 8'h1C;
	localparam logic [7:0] K28_3     = 8'h7C;
	localparam logic [7:0] K28_4     = 8'h9C;
	localparam logic [7:0] OCTET_NUL = 8'h00;

	// Link sequencing
	localparam logic [2:0] SYNC_MIN_FRAMES = 3'h4;
	localparam logic [1:0] ILA_LAST_MF     = 2'h3;
	localparam logic [5:0] ILA_CFG_FIRST   = 6'h02;
	localparam logic [5:0] ILA_CFG_LAST    = 6'h0F;
	localparam logic [5:0] ILA_Q_POS       = 6'h01;
	localparam logic [1:0] ILA_CFG_MF      = 2'h1;

	// Frames per multiframe, minus one
	localparam logic [4:0] KM1_MIN_SINGLE = 5'h08;
	localparam logic [4:0] KM1_MIN_DUAL   = 5'h10;

	// Reference pulse to multiframe clock delay, in device clocks
	localparam int SYSTEM_REFERENCE_PULSE_DELAY = 2;

	// Calibration lengths, in device clocks
	localparam int PLL_CAL_SAMPLE_CYCLES = 153000;
	localparam int ADC_CAL_CYCLES_DFLT   = 1024;
	localparam int CAL_W                 = 18;

	// Power mode codes; bit 0 set means power-down
	localparam logic [1:0] PM_NORMAL = 2'h0;
	localparam logic [1:0] PM_SLEEP  = 2'h2;

	// Link configuration octet fields
	localparam logic [7:0] ILA_DID      = 8'h00;
	localparam logic [3:0] ILA_BID      = 4'h0;
	localparam logic [7:0] ILA_M1       = 8'h00;
	localparam logic [1:0] ILA_CS       = 2'h0;
	localparam logic [4:0] ILA_N1       = 5'h0F;
	localparam logic [2:0] ILA_SUBCLASS = 3'h1;
	localparam logic [4:0] ILA_NP1      = 5'h0F;
	localparam logic [2:0] ILA_JESDV    = 3'h1;
	localparam logic [4:0] ILA_S1       = 5'h00;
	localparam logic [4:0] ILA_CF       = 5'h00;

	typedef enum logic [2:0] {
		ST_ADCCAL = 3'b000,
		ST_PLLCAL = 3'b001,
		ST_CGS    = 3'b011,
		ST_ILA    = 3'b010,
		ST_DATA   = 3'b110,
		ST_SLEEP  = 3'b111,
		ST_PDOWN  = 3'b101
	} slic_state_t;

	typedef struct packed {
		logic [4:0] kMinus1;
		logic       dualLane;
		logic       scrambleEn;
	} slic_cfg_t;

	typedef struct packed {
		logic       enable;
		logic       isK;
		logic       scramble;
		logic [7:0] octet;
	} slic_lane_t;

	// Bit 7 down to bit 0 of the link status register
	typedef struct packed {
		logic rsvd;
		logic link;
		logic sync;
		logic realign;
		logic align;
		logic pllLock;
		logic calDone;
		logic clkRdy;
	} slic_status_t;

endpackage

// ---- tb/slic_link_init_checker.sv ----
// Port-level assertions for the link bring-up controller
`timescale 1ns/100ps
module slic_link_init_checker
	import slic_pkg::*;
#(
	parameter int PLL_CAL_CYCLES = 40
) (
	// Clock and reset
	input wire logic                   mclk,
	input wire logic                   nrst,
	// Mode and sync pins
	input wire logic [1:0]             powerMode,
	input wire logic                   linkSyncRequestN,
	// Lanes and status
	input wire slic_lane_t [LANES-1:0] laneOut,
	input wire slic_status_t           linkStatusRegister
);
	wire slic_lane_t   l0 = laneOut[0];
	wire slic_status_t st = linkStatusRegister;
	logic [2:0]        mfEnds_q;
	logic [2:0]        mfEnds_d;
	logic [17:0]       calRun_q;
	logic [17:0]       calRun_d;

	// Alignment multiframe ends since the last comma
	assign mfEnds_d = (l0.isK && l0.octet == K28_5) ? 3'h0 :
		(l0.isK && l0.octet == K28_3 && mfEnds_q != 3'h7) ? mfEnds_q + 3'h1 : mfEnds_q;
	// Cycles of comma output before the PLL reports lock
	assign calRun_d = (l0.enable && !st.pllLock) ? calRun_q + 18'h00001 : 18'h00000;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mfEnds_q <= 3'h0;
			calRun_q <= 18'h00000;
		end else begin
			mfEnds_q <= mfEnds_d;
			calRun_q <= calRun_d;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	chk_ila_four_mf: assert property ($rose(st.link) |-> mfEnds_q == 3'h4)
		else $error("link up without four alignment multiframes");
	chk_ila_then_data: assert property ($rose(st.link) |-> $past(l0.isK) && $past(l0.octet) == K28_3)
		else $error("data did not follow the alignment sequence");
	chk_data_plain: assert property (st.link && $past(st.link) |-> l0.enable && !l0.isK)
		else $error("control character during data");
	chk_ila_unscrambled: assert property (st.pllLock && !st.link |-> !l0.scramble)
		else $error("alignment octet marked for scrambling");
	chk_sync_comma: assert property ((!linkSyncRequestN)[*8] ##1 (!linkSyncRequestN)[*6]
		##0 l0.enable |-> l0.isK && l0.octet == K28_5)
		else $error("no comma during a held sync request");
	chk_short_low: assert property (st.link && $rose(linkSyncRequestN) && !$past(linkSyncRequestN, 2)
		&& $past(linkSyncRequestN, 3) |-> st.link[*8])
		else $error("short sync low broke the link");
	chk_pll_first: assert property ($rose(st.pllLock) |-> calRun_q >= 18'(PLL_CAL_CYCLES - 1))
		else $error("lock reported before full PLL calibration");
	chk_sleep_off: assert property ((powerMode == PM_SLEEP)[*3] |-> !l0.enable && !st.link)
		else $error("lanes active in sleep");
	chk_pdown_cal: assert property (powerMode[0][*4] |-> !st.calDone)
		else $error("calibration done flag kept in power-down");
	chk_release_ila: assert property ($rose(linkSyncRequestN) && st.pllLock && !st.link
		|-> ##[1:80] (l0.isK && l0.octet == K28_0))
		else $error("alignment did not start after sync release");
endmodule

bind slic_link_init slic_link_init_checker #(.PLL_CAL_CYCLES(PLL_CAL_CYCLES)) i_slic_link_init_checker (
	.mclk(mclk),
	.nrst(nrst),
	.powerMode(powerMode),
	.linkSyncRequestN(linkSyncRequestN),
	.laneOut(laneOut),
	.linkStatusRegister(linkStatusRegister)
);

// ---- tb/slic_rx_model.sv ----
// Receiver model raising sync requests of commanded length
`timescale 1ns/100ps
module slic_rx_model (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       nrst,
	// Command from the bench
	input  wire logic       reqGo,
	input  wire logic [7:0] reqLen,
	// Sync request pin
	output wire logic       linkSyncRequestN
);
	logic [7:0] lowCnt_q;

	// Low exactly reqLen cycles; short lengths probe the filter
	assign linkSyncRequestN = (lowCnt_q == 8'h00);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lowCnt_q <= 8'h00;
		end else if (reqGo) begin
			lowCnt_q <= reqLen;
		end else if (lowCnt_q != 8'h00) begin
			lowCnt_q <= lowCnt_q - 8'h01;
		end
	end
endmodule

// ---- tb/test_slic_link_init.sv ----
// Self-checking bench for the link bring-up controller
`timescale 1ns/100ps
module test_slic_link_init;
	import slic_pkg::*;
	logic                   mclk;
	logic                   nrst;
	logic                   system_reference_pulse;
	logic                   sampleValid;
	logic                   reqGo;
	logic [1:0]             powerMode;
	logic [7:0]             reqLen;
	logic [SAMPLE_W-1:0]    sampleData;
	logic [SAMPLE_W-1:0]    smp [4];
	slic_cfg_t              cfg;
	wire logic              syncN;
	wire logic              sampleReady;
	wire slic_lane_t [LANES-1:0] lanes;
	wire slic_status_t      st;
	int                     err_total = 0;
	int                     num_checks = 0;
	int                     cyc = 0;
	int                     t0 = 0;

	// Short calibrations keep the run brief
	slic_link_init #(.PLL_CAL_CYCLES(40), .ADC_CAL_CYCLES(20)) i_slic_link_init (
		.mclk(mclk), .nrst(nrst), .cfg(cfg), .powerMode(powerMode),
		.linkSyncRequestN(syncN), .systemReferencePulse(system_reference_pulse),
		.sampleData(sampleData), .sampleValid(sampleValid), .sampleReady(sampleReady),
		.laneOut(lanes), .linkStatusRegister(st)
	);
	slic_rx_model i_slic_rx_model (
		.mclk(mclk), .nrst(nrst), .reqGo(reqGo), .reqLen(reqLen), .linkSyncRequestN(syncN)
	);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Multiframe length in device clocks, clamped like the hardware
	function automatic int mfCycles(input slic_cfg_t c);
		logic [4:0] minK;
		minK = c.dualLane ? KM1_MIN_DUAL : KM1_MIN_SINGLE;
		return (c.dualLane ? 1 : 2) * ((c.kMinus1 < minK ? int'(minK) : int'(c.kMinus1)) + 1);
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// Measures alignment length from its first octet to link up
	task automatic bringUp(input int expLen);
		int n;
		n = 0;
		while (!(lanes[0].isK === 1'b1 && lanes[0].octet === K28_0) && n < 3000) begin
			tick(1);
			n++;
		end
		check(16'(n < 3000), 16'h0001);
		n = 0;
		while (st.link !== 1'b1 && n < 3000) begin
			tick(1);
			n++;
		end
		check(16'(n), 16'(expLen));
	endtask

	task automatic syncReq(input logic [7:0] len);
		@(posedge mclk);
		reqGo <= 1'b1;
		reqLen <= len;
		@(posedge mclk);
		reqGo <= 1'b0;
	endtask

	// Only issued in data transmission, never during calibration
	task automatic pulseAt(input int base, input int off);
		while ((cyc - base) % mfCycles(cfg) != off) tick(1);
		t0 = cyc;
		@(posedge mclk);
		system_reference_pulse <= 1'b1;
		@(posedge mclk);
		system_reference_pulse <= 1'b0;
	endtask

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	always @(posedge mclk) cyc <= cyc + 1;

	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		summarize();
	end

	initial begin
		nrst = 1'b0;
		system_reference_pulse = 1'b0;
		sampleValid = 1'b0;
		sampleData = 16'h0000;
		reqGo = 1'b0;
		reqLen = 8'h00;
		powerMode = PM_NORMAL;
		void'($urandom(32'h5681));
		cfg = '{kMinus1: 5'($urandom_range(31, 8)), dualLane: 1'b0, scrambleEn: 1'b1};
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		// Samples queue until data transmission starts
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			smp[i] = 16'($urandom);
			sampleData <= smp[i];
			sampleValid <= 1'b1;
		end
		@(posedge mclk);
		sampleValid <= 1'b0;
		tick(1);
		check(16'(sampleReady), 16'h0001);
		bringUp(4 * mfCycles(cfg));
		check(16'({lanes[0].scramble, lanes[1].enable}), 16'h0002);
		for (int i = 0; i < 8; i++) begin
			check(16'(lanes[0].octet), 16'(i[0] ? smp[i / 2][7:0] : smp[i / 2][15:8]));
			tick(1);
		end
		syncReq(8'h02);
		tick(20);
		check(16'(st.link), 16'h0001);
		syncReq(8'($urandom_range(40, 16)));
		tick(14);
		check(16'({st.link, lanes[0].isK, lanes[0].octet}), 16'({2'b01, K28_5}));
		bringUp(4 * mfCycles(cfg));
		// Half a multiframe off is misaligned whatever the first pulse did
		pulseAt(cyc, 0);
		tick(12);
		if (st.link !== 1'b1) begin
			bringUp(4 * mfCycles(cfg));
		end
		pulseAt(t0, mfCycles(cfg) / 2);
		tick(12);
		check(16'({st.realign, st.pllLock, st.link}), 16'h0004);
		bringUp(4 * mfCycles(cfg));
		pulseAt(t0, 0);
		tick(12);
		check(16'({st.align, st.link}), 16'h0003);
		@(posedge mclk);
		powerMode <= PM_SLEEP;
		cfg <= '{kMinus1: 5'h05, dualLane: 1'b1, scrambleEn: 1'b0};
		tick(6);
		check(16'({lanes[0].enable, st.link}), 16'h0000);
		@(posedge mclk);
		powerMode <= PM_NORMAL;
		tick(4);
		check(16'({st.calDone, lanes[0].enable}), 16'h0003);
		bringUp(4 * mfCycles(cfg));
		check(16'({lanes[1].enable, lanes[1].isK, lanes[1].scramble}), 16'h0004);
		@(posedge mclk);
		powerMode <= 2'h1;
		cfg.kMinus1 <= 5'($urandom_range(31, 16));
		tick(6);
		check(16'(st.calDone), 16'h0000);
		@(posedge mclk);
		powerMode <= PM_NORMAL;
		bringUp(4 * mfCycles(cfg));
		summarize();
	end
endmodule
